// ---- pkg/clk_gen_pkg.sv ----
// constants, types and carriers for the clock generator control block
package clk_gen_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int RATIO_W = 7;

   // register map
   localparam logic [ADDR_W-1:0] MODE_ADDR = 8'h58;

   // field layout of clock_mode_reg
   localparam int MULT_MSB = 15;
   localparam int MULT_LSB = 12;
   localparam int FRAC_BIT = 11;
   localparam int CNT_MSB = 10;
   localparam int CNT_LSB = 3;
   localparam int FORCE_BIT = 2;
   localparam int PND_BIT = 1;
   localparam int STATUS_BIT = 0;

   // reset: pll mode, integer, multiplier field at bypass code
   localparam logic [DATA_W-1:0] MODE_RESET = 16'hF002;

   localparam logic [3:0] MULT_BYPASS = 4'hF;
   localparam logic [3:0] PRESCALE_LAST = 4'hF;
   localparam logic [3:0] PRESCALE_ZERO = 4'h0;
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic [4:0] MULT_INC = 5'h01;

   // core clock ratio in quarters of the reference clock
   localparam logic [RATIO_W-1:0] RATIO_QUARTER = 7'h01;
   localparam logic [RATIO_W-1:0] RATIO_HALF = 7'h02;
   localparam logic [RATIO_W-1:0] RATIO_ONE = 7'h04;

   typedef enum logic [1:0]
   {
      ST_DIV = 2'b00,
      ST_LOCK = 2'b01,
      ST_PLL = 2'b11
   } clk_state_t;

   typedef struct packed
   {
      logic [3:0] mult_field;
      logic frac_select;
      logic [7:0] lock_count_field;
      logic vco_force_on;
      logic pll_not_div_select;
      logic status;
   } mode_reg_t;

   typedef struct packed
   {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
      logic subsys_b;
   } bus_req_t;

   typedef struct packed
   {
      logic vco_on;
      logic pll_select;
      logic [RATIO_W-1:0] ratio;
   } clk_ctrl_t;

endpackage

// ---- logic/pll_clock_mode_and_lock_timer.sv ----
// clock mode register, lock timer and core clock ratio selection
//
// Local design decision: the plain strobed port.
module pll_clock_mode_and_lock_timer
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   input wire clk_gen_pkg::bus_req_t bus_req_in,
   output logic [clk_gen_pkg::DATA_W-1:0] rd_data_out,
   output clk_gen_pkg::clk_ctrl_t clk_ctrl_out
);
   import clk_gen_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // register access decode

   logic hit;
   logic mode_wr;
   logic mode_rd;
   mode_reg_t wr_fields;

   // subsystem b is shut out entirely: no store, no state change, reads zero
   assign hit = (bus_req_in.addr == MODE_ADDR) && !bus_req_in.subsys_b;
   assign mode_wr = hit && bus_req_in.wr;
   assign mode_rd = hit && bus_req_in.rd;
   assign wr_fields = mode_reg_t'(bus_req_in.wdata);

   ////////////////////////////////////////////////////////////////////////////
   // mode register and lock timer state

   mode_reg_t mode_r;
   mode_reg_t mode_nxt;
   clk_state_t state_r;
   clk_state_t state_nxt;
   logic [7:0] lock_cnt_r;
   logic [7:0] lock_cnt_nxt;
   logic [3:0] prescale_r;
   logic [3:0] prescale_nxt;

   always_comb
   begin
      mode_nxt = mode_r;
      state_nxt = state_r;
      lock_cnt_nxt = lock_cnt_r;
      prescale_nxt = prescale_r;
      if (clk_en_in)
      begin
         if (mode_wr)
         begin
            mode_nxt = wr_fields;
            // status is owned by the state machine, never by software
            mode_nxt.status = 1'b0;
         end
         unique case (state_r)
            ST_DIV:
            begin
               if (mode_wr && wr_fields.pll_not_div_select)
               begin
                  state_nxt = ST_LOCK;
                  lock_cnt_nxt = wr_fields.lock_count_field;
                  prescale_nxt = PRESCALE_ZERO;
               end
            end
            ST_LOCK:
            begin
               if (mode_wr && !wr_fields.pll_not_div_select)
               begin
                  state_nxt = ST_DIV;
               end
               else if (lock_cnt_r == CNT_ZERO)
               begin
                  state_nxt = ST_PLL;
               end
               else
               begin
                  // divide-by-16 tick counted in enabled core_clk_in cycles
                  prescale_nxt = prescale_r + 4'h1;
                  if (prescale_r == PRESCALE_LAST)
                  begin
                     lock_cnt_nxt = lock_cnt_r - CNT_ONE;
                  end
               end
            end
            ST_PLL:
            begin
               // retuning while in pll mode takes effect at once, no relock wait
               if (mode_wr && !wr_fields.pll_not_div_select)
               begin
                  state_nxt = ST_DIV;
               end
            end
            default:
            begin
               state_nxt = ST_DIV;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         mode_r <= mode_reg_t'(MODE_RESET);
         state_r <= ST_PLL;
         lock_cnt_r <= CNT_ZERO;
         prescale_r <= PRESCALE_ZERO;
      end
      else
      begin
         mode_r <= mode_nxt;
         state_r <= state_nxt;
         lock_cnt_r <= lock_cnt_nxt;
         prescale_r <= prescale_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock ratio and oscillator control

   logic [4:0] mult_inc_nxt;
   clk_ctrl_t ctrl_r;
   clk_ctrl_t ctrl_nxt;

   assign mult_inc_nxt = {1'b0, mode_nxt.mult_field} + MULT_INC;

   always_comb
   begin
      ctrl_nxt = ctrl_r;
      if (clk_en_in)
      begin
         ctrl_nxt.vco_on = mode_nxt.vco_force_on || mode_nxt.pll_not_div_select;
         ctrl_nxt.pll_select = (state_nxt == ST_PLL);
         if (state_nxt != ST_PLL)
         begin
            // while locking the divider ratio still clocks the core
            if (mode_nxt.mult_field == MULT_BYPASS)
            begin
               ctrl_nxt.ratio = RATIO_QUARTER;
            end
            else
            begin
               ctrl_nxt.ratio = RATIO_HALF;
            end
         end
         else if (!mode_nxt.frac_select)
         begin
            if (mode_nxt.mult_field == MULT_BYPASS)
            begin
               ctrl_nxt.ratio = RATIO_ONE;
            end
            else
            begin
               ctrl_nxt.ratio = {mult_inc_nxt, 2'b00};
            end
         end
         else if (!mode_nxt.mult_field[0])
         begin
            ctrl_nxt.ratio = {1'b0, mult_inc_nxt, 1'b0};
         end
         else
         begin
            ctrl_nxt.ratio = {3'h0, mode_nxt.mult_field};
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ctrl_r.vco_on <= 1'b1;
         ctrl_r.pll_select <= 1'b1;
         ctrl_r.ratio <= RATIO_ONE;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
      end
   end

   assign clk_ctrl_out = ctrl_r;

   ////////////////////////////////////////////////////////////////////////////
   // read data, one cycle after the strobe

   logic [DATA_W-1:0] rd_data_r;
   logic [DATA_W-1:0] rd_data_nxt;
   mode_reg_t rd_view;

   always_comb
   begin
      rd_view = mode_r;
      // fields are read back as stored even in divider mode, where the multiplier field still picks the quarter or half ratio
      rd_view.status = (state_r == ST_PLL);
      rd_data_nxt = rd_data_r;
      if (clk_en_in)
      begin
         if (mode_rd)
         begin
            rd_data_nxt = DATA_W'(rd_view);
         end
         else
         begin
            rd_data_nxt = '0;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rd_data_r <= '0;
      end
      else
      begin
         rd_data_r <= rd_data_nxt;
      end
   end

   assign rd_data_out = rd_data_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   logic any_b_access;
   assign any_b_access = bus_req_in.subsys_b && (bus_req_in.wr || bus_req_in.rd);

   // the lock timer keeps running through a subsystem b access, so state may still move
   b_access_ignored_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      clk_en_in && any_b_access |=> $stable(mode_r) && (rd_data_out == '0)
         && ($stable(state_r) || ($past(state_r) == ST_LOCK)))
      else $error("subsystem b access changed the clock generator");

   reset_bypass_a: assert property (
      @(posedge core_clk_in)
      $rose(rst_n_in) |-> (clk_ctrl_out.ratio == RATIO_ONE) && clk_ctrl_out.pll_select)
      else $error("clock not in bypass after reset");

   div_ratio_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r != ST_PLL) |-> (clk_ctrl_out.ratio ==
         ((mode_r.mult_field == MULT_BYPASS) ? RATIO_QUARTER : RATIO_HALF)))
      else $error("wrong divider mode ratio");

   pll_int_ratio_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == ST_PLL) && !mode_r.frac_select |-> (clk_ctrl_out.ratio ==
         ((mode_r.mult_field == MULT_BYPASS) ? RATIO_ONE :
          RATIO_W'(({3'h0, mode_r.mult_field} + 7'h01) * 7'h04))))
      else $error("wrong integer pll ratio");

   pll_frac_ratio_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == ST_PLL) && mode_r.frac_select |-> (clk_ctrl_out.ratio ==
         (mode_r.mult_field[0] ? {3'h0, mode_r.mult_field} :
          RATIO_W'(({3'h0, mode_r.mult_field} + 7'h01) * 7'h02))))
      else $error("wrong fractional pll ratio");

   vco_enable_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      clk_ctrl_out.vco_on == (mode_r.vco_force_on || mode_r.pll_not_div_select))
      else $error("oscillator enable mismatch");

   status_read_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      clk_en_in && mode_rd |=> rd_data_out[STATUS_BIT] == $past(state_r == ST_PLL))
      else $error("status bit does not match clock mode");

   lock_start_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      clk_en_in && (state_r == ST_DIV) && mode_wr && wr_fields.pll_not_div_select
      |=> (state_r == ST_LOCK) && (lock_cnt_r == $past(wr_fields.lock_count_field))
          && !clk_ctrl_out.pll_select)
      else $error("lock timer not started by switch to pll");

   lock_step_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      clk_en_in && (state_r == ST_LOCK) && (lock_cnt_r != CNT_ZERO) && !mode_wr
      |=> (lock_cnt_r == $past(lock_cnt_r) - ($past(prescale_r) == PRESCALE_LAST)))
      else $error("lock timer stepped at wrong rate");

   lock_hold_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == ST_LOCK) && (lock_cnt_r != CNT_ZERO) |=> (state_r != ST_PLL))
      else $error("pll took over before lock timer expired");

   div_return_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      clk_en_in && mode_wr && !wr_fields.pll_not_div_select
      |=> (state_r == ST_DIV) && !clk_ctrl_out.pll_select)
      else $error("divider selection did not return to divider mode");

   lock_expire_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      clk_en_in && (state_r == ST_LOCK) && (lock_cnt_r == CNT_ZERO) && !mode_wr
      |=> (state_r == ST_PLL) && clk_ctrl_out.pll_select)
      else $error("pll did not take over after lock timer expiry");

   prescale_start_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      clk_en_in && (state_r == ST_DIV) && mode_wr && wr_fields.pll_not_div_select
      |=> (prescale_r == PRESCALE_ZERO))
      else $error("lock prescaler not cleared at timer start");

   pll_select_state_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      clk_ctrl_out.pll_select == (state_r == ST_PLL))
      else $error("pll select does not follow the clock state");

   lock_vco_on_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      (state_r == ST_LOCK) |-> clk_ctrl_out.vco_on)
      else $error("oscillator off while the lock timer runs");

   // idle read data is zero so several slaves can share one read bus
   read_idle_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      clk_en_in && !mode_rd |=> (rd_data_out == '0))
      else $error("read data not zero outside a subsystem a read");

   // a low enable stalls the lock timer too, which stretches the lock wait
   enable_freeze_a: assert property (
      @(posedge core_clk_in) disable iff (!rst_n_in)
      !clk_en_in |=> $stable(mode_r) && $stable(state_r) && $stable(lock_cnt_r)
         && $stable(clk_ctrl_out) && $stable(rd_data_out))
      else $error("state moved while clock enable was low");

endmodule

// ---- dv/host_model.sv ----
// subsystem A and B software model driving single-cycle strobes on the mode register port
module host_model
(
   input wire logic core_clk_in,
   input wire logic [clk_gen_pkg::DATA_W-1:0] rd_data_in,
   output clk_gen_pkg::bus_req_t bus_req_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import clk_gen_pkg::*;

   initial bus_req_out = '0;

   ////////////////////////////////////////////////////////////////////////////////
   // one access: strobe for one cycle, read data taken in the following cycle
   task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic b, output logic [DATA_W-1:0] q);
      @(posedge core_clk_in);
      bus_req_out <= '{addr: a, wdata: d, wr: wr, rd: !wr, subsys_b: b};
      @(posedge core_clk_in);
      bus_req_out.wr <= 1'b0;
      bus_req_out.rd <= 1'b0;
      // stale write data is inverted so nothing can lean on it
      bus_req_out.wdata <= ~d;
      #1;
      q = rd_data_in;
   endtask
endmodule

// ---- dv/tb_top.sv ----
// self-checking testbench for the clock mode register and lock timer
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import clk_gen_pkg::*;

   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic clk_en_in = 1'b1;
   bus_req_t bus_req;
   logic [DATA_W-1:0] rd_data;
   clk_ctrl_t ctrl;
   int num_errors = 0;
   int samples_checked = 0;

   always #4 core_clk_in = ~core_clk_in;

   pll_clock_mode_and_lock_timer i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
      .clk_en_in(clk_en_in), .bus_req_in(bus_req), .rd_data_out(rd_data),
      .clk_ctrl_out(ctrl));

   host_model i_host (.core_clk_in(core_clk_in), .rd_data_in(rd_data), .bus_req_out(bus_req));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic ok, input string m);
      samples_checked++;
      if (ok !== 1'b1)
      begin
         num_errors++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask

   task automatic test_done();
      if (num_errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic wr(input logic [DATA_W-1:0] d, input logic b = 1'b0);
      logic [DATA_W-1:0] q;
      i_host.access(1'b1, MODE_ADDR, d, b, q);
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic b,
      input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] msk, input string m);
      logic [DATA_W-1:0] q;
      i_host.access(1'b0, a, 16'h0000, b, q);
      chk((q & msk) === (exp & msk), m);
   endtask

   // registered control output settles within two edges of the write
   task automatic ctrl_chk(input logic [8:0] exp, input string m);
      repeat (2) @(posedge core_clk_in);
      #1;
      chk(ctrl === exp, m);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_and_b();
      ctrl_chk({1'b1, 1'b1, 7'h04}, "reset control not bypass");
      rd_chk(MODE_ADDR, 1'b0, 16'hF003, 16'hFFFF, "reset read back");
      wr(16'h0000, 1'b1);
      ctrl_chk({1'b1, 1'b1, 7'h04}, "subsystem B write took effect");
      rd_chk(MODE_ADDR, 1'b1, 16'h0000, 16'hFFFF, "subsystem B read not zero");
      rd_chk(8'h59, 1'b0, 16'h0000, 16'hFFFF, "unmapped read not zero");
   endtask

   task automatic t_divider();
      wr(16'h0000);
      ctrl_chk({1'b0, 1'b0, 7'h02}, "divide by two or oscillator off");
      rd_chk(MODE_ADDR, 1'b0, 16'h0000, 16'h0003, "status not divider");
      wr(16'hF004);
      ctrl_chk({1'b1, 1'b0, 7'h01}, "divide by four or force on");
   endtask

   // preset n, multiplier 3: divider clock must hold for 16*n core clock cycles
   task automatic t_lock(input logic [7:0] n);
      int i;
      wr(16'h0000);
      ctrl_chk({1'b0, 1'b0, 7'h02}, "not in divider before lock");
      wr({4'h3, 1'b0, n, 1'b0, 1'b1, 1'b0});
      repeat (16 * n) @(posedge core_clk_in);
      #1;
      chk(ctrl.pll_select === 1'b0 && ctrl.ratio === 7'h02, "pll took over early");
      chk(ctrl.vco_on === 1'b1, "oscillator off during lock");
      i = 0;
      while (ctrl.pll_select !== 1'b1 && i < 6)
      begin
         @(posedge core_clk_in);
         #1;
         i++;
      end
      chk(i == 1, "pll takeover not one cycle after expiry");
      if (i >= 6)
         test_done();
      chk(ctrl.ratio === 7'h10, "integer ratio after lock");
      rd_chk(MODE_ADDR, 1'b0, 16'h0001, 16'h0001, "status not pll after lock");
   endtask

   task automatic t_ratios();
      logic [4:0] m [5] = '{5'h09, 5'h0B, 5'h01, 5'h1E, 5'h1C};
      logic [6:0] r [5] = '{7'h0A, 7'h05, 7'h02, 7'h04, 7'h3C};
      for (int k = 0; k < 5; k++)
      begin
         wr({m[k][4:1], m[k][0], 8'h00, 1'b0, 1'b1, 1'b0});
         ctrl_chk({1'b1, 1'b1, r[k]}, "pll ratio");
      end
      wr(16'h3000);
      ctrl_chk({1'b0, 1'b0, 7'h02}, "back to divider");
      rd_chk(MODE_ADDR, 1'b0, 16'h0000, 16'h0001, "status not cleared");
   endtask

   // a write while the enable is low is lost and control holds
   task automatic t_freeze();
      @(posedge core_clk_in);
      clk_en_in <= 1'b0;
      wr(16'hF006);
      ctrl_chk({1'b0, 1'b0, 7'h02}, "control moved while clock enable low");
      @(posedge core_clk_in);
      clk_en_in <= 1'b1;
      rd_chk(MODE_ADDR, 1'b0, 16'h0000, 16'h0003, "write taken while enable low");
   endtask

   // divider selection during the lock wait cancels it; a status write is ignored
   task automatic t_abort();
      wr({4'h3, 1'b0, 8'h04, 1'b0, 1'b1, 1'b0});
      ctrl_chk({1'b1, 1'b0, 7'h02}, "divider clock not held while locking");
      wr(16'h3001);
      ctrl_chk({1'b0, 1'b0, 7'h02}, "lock wait not cancelled");
      rd_chk(MODE_ADDR, 1'b0, 16'h0000, 16'h0003, "status after cancel");
   endtask

   // reset in mid-run brings divider mode back to bypass
   task automatic t_reset_mid();
      @(posedge core_clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      ctrl_chk({1'b1, 1'b1, 7'h04}, "control not bypass after reset");
      rd_chk(MODE_ADDR, 1'b0, 16'hF003, 16'hFFFF, "read back after reset");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      t_reset_and_b();
      t_divider();
      t_lock(8'h00);
      t_lock(8'h02);
      t_ratios();
      t_freeze();
      t_abort();
      t_reset_mid();
      test_done();
   end
endmodule
